// >>> src/codec_ctrl_regs.vh
// Behaviour
// - Registers hold eight bits, one frame; the output source register keeps bit 0 only
// - Pull data low only for ack/read data
// - Works at 100k and 400k bit rates
// - Answer prefix 00100 plus two address pins
// - Write: address, index, data, each acknowledged
// - Index frame carries index in upper seven bits
// - Read: index write, restart, then data frames
// - Block write stores into next index
// - Block read increments index per acknowledged frame
// - Buffer registers advance buffer pointer instead
// - Output source: transmitter or receiver loopback
`ifndef CODEC_CTRL_REGS_VH
`define CODEC_CTRL_REGS_VH

// ****************************************************************
// Bus address and register map
// ****************************************************************
`define DEV_PREFIX 5'h04
`define IDX_CLOCK_CTRL 7'h00
`define IDX_SPDIF_SRC 7'h03
// Buffer style registers, reached through a pointer
`define IDX_INDIRECT_ADDR 7'h7C
`define IDX_TX_USER_BUF 7'h7D
`define IDX_RX_USER_BUF 7'h7E

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CONV_DIV_HI 7
`define CONV_DIV_LO 6
`define CLK2_DIV_HI 5
`define CLK2_DIV_LO 4
`define CLK1_DIV_HI 3
`define CLK1_DIV_LO 2
`define CONV_SRC_HI 1
`define CONV_SRC_LO 0
`define SPDIF_SRC_BIT 0
`define CLOCK_CTRL_RESET 8'h00
`define SPDIF_SRC_RESET 1'b0

// ****************************************************************
// Encodings and counts
// ****************************************************************
`define DIV_BY_1 2'h0
`define DIV_BY_1P5 2'h1
`define DIV_BY_2 2'h2
`define DIV_BY_3 2'h3
`define SRC_CLK_ONE 2'h0
`define SRC_CLK_TWO 2'h1
`define SRC_PLL_512 2'h2
`define SRC_PLL_256 2'h3
`define BITS_PER_FRAME 4'h8

`endif

// >>> src/tick_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_regs.vh"

// Divides a stream of one-cycle ticks by 1, 1.5, 2 or 3
module tick_divider (
  input wire clk_sys,
  input wire rst_n,
  input wire tick_in,
  input wire [1:0] ratio,
  output reg tick_out_ff
);

  reg [1:0] cnt_ff; // Position within the pattern
  reg [1:0] nxt_cnt;
  reg nxt_tick;

  // ****************************************************************
  // Pattern: 1.5 passes two of every three ticks, so rate is exact
  // ****************************************************************
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (tick_in) begin
      case (ratio)
        `DIV_BY_1: begin
          nxt_tick = 1'b1;
          nxt_cnt = 2'h0;
        end
        `DIV_BY_1P5: begin
          nxt_tick = (cnt_ff != 2'h2);
          nxt_cnt = (cnt_ff >= 2'h2) ? 2'h0 : cnt_ff + 2'h1;
        end
        `DIV_BY_2: begin
          nxt_tick = (cnt_ff == 2'h0);
          nxt_cnt = (cnt_ff >= 2'h1) ? 2'h0 : cnt_ff + 2'h1;
        end
        default: begin
          nxt_tick = (cnt_ff == 2'h0);
          nxt_cnt = (cnt_ff >= 2'h2) ? 2'h0 : cnt_ff + 2'h1;
        end
      endcase
    end
  end

  // State update
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_ff <= 2'h0;
      tick_out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_out_ff <= nxt_tick;
    end
  end

endmodule // tick_divider
`default_nettype wire

// >>> src/reg_store.v
`timescale 1ns/1ps
`default_nettype none

// Backing store for registers and buffers, registered read
module reg_store (
  input wire clk_sys,
  input wire rst_n,
  input wire wr_en,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata_ff
);

  reg [7:0] mem [0:255]; // Contents have no reset, as on silicon

  // Write port
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  // Read port, one cycle behind the address
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= mem[addr];
    end
  end

endmodule // reg_store
`default_nettype wire

// >>> src/codec_i2c_control_port.v
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctrl_regs.vh"

// Two-wire control target with clock control and output select
module codec_i2c_control_port (
  input wire clk_sys,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_ff,
  output reg sda_oe_n_ff,
  input wire bus_address_select_hi,
  input wire bus_address_select_lo,
  input wire internal_clock_one,
  input wire internal_clock_two,
  input wire pll_512fs_tick,
  input wire pll_256fs_tick,
  input wire transmitter_out,
  input wire spdif_input_pin,
  output reg spdif_output_pin,
  output wire clk_one_div_tick,
  output wire clk_two_div_tick,
  output wire converter_clock_tick,
  output reg [7:0] clock_ctrl_ff,
  output reg spdif_out_source_ff
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [3:0] ST_IDLE = 4'h0, ST_DEV = 4'h1, ST_DEV_ACK = 4'h2;
  localparam [3:0] ST_REG = 4'h3, ST_REG_ACK = 4'h4, ST_WR = 4'h5;
  localparam [3:0] ST_WR_ACK = 4'h6, ST_RD = 4'h7, ST_RD_ACK = 4'h8;

  // True for registers whose block access walks a buffer
  function is_buffer(input [6:0] idx);
    is_buffer = (idx == `IDX_INDIRECT_ADDR) || (idx == `IDX_TX_USER_BUF) || (idx == `IDX_RX_USER_BUF);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg scl_ff, sda_ff; // Sampled clock and data lines
  reg scl_prev_ff, sda_prev_ff; // Previous samples, for edges and start/stop
  reg [3:0] state_ff, nxt_state; // Protocol state
  reg [3:0] bitcnt_ff, nxt_bitcnt; // Bits received or sent in the frame
  reg [7:0] shift_ff, nxt_shift; // Frame shifter, in and out
  reg [6:0] index_ff, nxt_index; // Register index, kept across transfers
  reg [4:0] buf_ptr_ff, nxt_buf_ptr; // Position inside a buffer register
  reg master_nack_ff, nxt_master_nack; // Master refused further read data
  reg nxt_sda_oe_n, nxt_spdif_src; // Next pin enable and output source
  reg [7:0] nxt_clock_ctrl;
  reg store_wr; // Write strobe into backing store
  reg [7:0] read_value; // Value offered to a read frame
  wire [7:0] store_rdata, store_addr;
  wire scl_rise, scl_fall, start_cond, stop_cond;
  wire [6:0] own_addr;
  wire [1:0] conv_src;
  reg conv_src_tick; // Selected source before division

  // ****************************************************************
  // Line sampling and bus conditions
  // ****************************************************************
  // Inputs are synchronous, one sample stage is enough for edges
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_ff <= scl_in;
      sda_ff <= sda_in;
      scl_prev_ff <= scl_ff;
      sda_prev_ff <= sda_ff;
    end
  end

  // Data may move only with the clock low; a move with it high is start or stop
  assign scl_rise = scl_ff & ~scl_prev_ff;
  assign scl_fall = ~scl_ff & scl_prev_ff;
  assign start_cond = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
  assign stop_cond = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;
  assign own_addr = {`DEV_PREFIX, bus_address_select_hi, bus_address_select_lo};

  // ****************************************************************
  // Storage address: buffers are mapped above the plain registers
  // ****************************************************************
  assign store_addr = is_buffer(index_ff) ? {1'b1, index_ff[1:0], buf_ptr_ff} : {1'b0, index_ff};

  // Read value: two registers live in flops, the rest in the store
  always @* begin
    case (index_ff)
      `IDX_CLOCK_CTRL: read_value = clock_ctrl_ff;
      `IDX_SPDIF_SRC: read_value = {7'h00, spdif_out_source_ff};
      default: read_value = store_rdata;
    endcase
  end

  reg_store u_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(store_wr),
    .addr(store_addr),
    .wdata(shift_ff),
    .rdata_ff(store_rdata)
  );

  // ****************************************************************
  // Protocol engine
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_index = index_ff;
    nxt_buf_ptr = buf_ptr_ff;
    nxt_master_nack = master_nack_ff;
    nxt_sda_oe_n = sda_oe_n_ff;
    nxt_clock_ctrl = clock_ctrl_ff;
    nxt_spdif_src = spdif_out_source_ff;
    store_wr = 1'b0;
    if (start_cond) begin
      // Repeated start too: a fresh address frame follows
      nxt_state = ST_DEV;
      nxt_bitcnt = 4'h0;
      nxt_sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      // Index is kept so a later read returns it
      nxt_state = ST_IDLE;
      nxt_sda_oe_n = 1'b1;
    end else begin
      // Receive states shift a bit in on each rising clock
      if (scl_rise && (state_ff == ST_DEV || state_ff == ST_REG || state_ff == ST_WR)) begin
        nxt_shift = {shift_ff[6:0], sda_ff};
        nxt_bitcnt = bitcnt_ff + 4'h1;
      end
      case (state_ff)
        ST_IDLE: begin
          nxt_sda_oe_n = 1'b1;
        end
        ST_DEV: begin
          if (scl_fall && bitcnt_ff == `BITS_PER_FRAME) begin
            if (shift_ff[7:1] == own_addr) begin
              nxt_sda_oe_n = 1'b0;
              nxt_state = ST_DEV_ACK;
            end else begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_DEV_ACK: begin
          if (scl_fall) begin
            nxt_bitcnt = 4'h0;
            if (shift_ff[0]) begin
              // Read: first data bit goes out now
              nxt_state = ST_RD;
              nxt_shift = {read_value[6:0], 1'b0};
              nxt_sda_oe_n = read_value[7];
            end else begin
              nxt_state = ST_REG;
              nxt_sda_oe_n = 1'b1;
            end
          end
        end
        ST_REG: begin
          if (scl_fall && bitcnt_ff == `BITS_PER_FRAME) begin
            // Index sits in the upper seven bits of the frame
            nxt_index = shift_ff[7:1];
            nxt_buf_ptr = 5'h00;
            nxt_sda_oe_n = 1'b0;
            nxt_state = ST_REG_ACK;
          end
        end
        ST_REG_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe_n = 1'b1;
            nxt_bitcnt = 4'h0;
            nxt_state = ST_WR;
          end
        end
        ST_WR: begin
          if (scl_fall && bitcnt_ff == `BITS_PER_FRAME) begin
            // Eight-bit value lands in one register; the output source register keeps bit 0 only
            case (index_ff)
              `IDX_CLOCK_CTRL: nxt_clock_ctrl = shift_ff;
              `IDX_SPDIF_SRC: nxt_spdif_src = shift_ff[`SPDIF_SRC_BIT];
              default: store_wr = 1'b1;
            endcase
            nxt_sda_oe_n = 1'b0;
            nxt_state = ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe_n = 1'b1;
            nxt_bitcnt = 4'h0;
            nxt_state = ST_WR;
            if (is_buffer(index_ff)) begin
              nxt_buf_ptr = buf_ptr_ff + 5'h01;
            end else begin
              nxt_index = index_ff + 7'h01;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end
          if (scl_fall) begin
            if (bitcnt_ff == `BITS_PER_FRAME) begin
              // Release for the master's acknowledge
              nxt_sda_oe_n = 1'b1;
              nxt_state = ST_RD_ACK;
            end else begin
              nxt_sda_oe_n = shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nxt_master_nack = sda_ff;
            // Advance early so the store has settled by the falling edge
            if (!sda_ff) begin
              if (is_buffer(index_ff)) begin
                nxt_buf_ptr = buf_ptr_ff + 5'h01;
              end else begin
                nxt_index = index_ff + 7'h01;
              end
            end
          end
          if (scl_fall) begin
            nxt_bitcnt = 4'h0;
            if (master_nack_ff) begin
              nxt_state = ST_IDLE;
            end else begin
              nxt_state = ST_RD;
              nxt_shift = {read_value[6:0], 1'b0};
              nxt_sda_oe_n = read_value[7];
            end
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Engine registers; open-drain pin only ever pulls low
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      index_ff <= 7'h00;
      buf_ptr_ff <= 5'h00;
      master_nack_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
      clock_ctrl_ff <= `CLOCK_CTRL_RESET;
      spdif_out_source_ff <= `SPDIF_SRC_RESET;
    end else begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      index_ff <= nxt_index;
      buf_ptr_ff <= nxt_buf_ptr;
      master_nack_ff <= nxt_master_nack;
      sda_out_ff <= 1'b0;
      sda_oe_n_ff <= nxt_sda_oe_n;
      clock_ctrl_ff <= nxt_clock_ctrl;
      spdif_out_source_ff <= nxt_spdif_src;
    end
  end

  // ****************************************************************
  // Clock division and source selection
  // ****************************************************************
  tick_divider u_div_one (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_in(internal_clock_one),
    .ratio(clock_ctrl_ff[`CLK1_DIV_HI:`CLK1_DIV_LO]),
    .tick_out_ff(clk_one_div_tick)
  );

  tick_divider u_div_two (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_in(internal_clock_two),
    .ratio(clock_ctrl_ff[`CLK2_DIV_HI:`CLK2_DIV_LO]),
    .tick_out_ff(clk_two_div_tick)
  );

  assign conv_src = clock_ctrl_ff[`CONV_SRC_HI:`CONV_SRC_LO];

  // Source mux ahead of the converter divider
  always @* begin
    case (conv_src)
      `SRC_CLK_ONE: conv_src_tick = clk_one_div_tick;
      `SRC_CLK_TWO: conv_src_tick = clk_two_div_tick;
      `SRC_PLL_512: conv_src_tick = pll_512fs_tick;
      `SRC_PLL_256: conv_src_tick = pll_256fs_tick;
      default: conv_src_tick = 1'b0;
    endcase
  end

  tick_divider u_div_conv (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_in(conv_src_tick),
    .ratio(clock_ctrl_ff[`CONV_DIV_HI:`CONV_DIV_LO]),
    .tick_out_ff(converter_clock_tick)
  );

  // ****************************************************************
  // Output source: transmitter or straight loopback of the input
  // ****************************************************************
  // Loopback adds one cycle of delay; fine for a sampled bit stream
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      spdif_output_pin <= 1'b0;
    end else begin
      spdif_output_pin <= spdif_out_source_ff ? spdif_input_pin : transmitter_out;
    end
  end

endmodule // codec_i2c_control_port
`default_nettype wire

// >>> tb/codec_i2c_control_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module ctrl_port_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out_ff,
  input wire logic sda_oe_n_ff,
  input wire logic internal_clock_one,
  input wire logic pll_512fs_tick,
  input wire logic pll_256fs_tick,
  input wire logic transmitter_out,
  input wire logic spdif_input_pin,
  input wire logic spdif_output_pin,
  input wire logic clk_two_div_tick,
  input wire logic clk_one_div_tick,
  input wire logic converter_clock_tick,
  input wire logic [7:0] clock_ctrl_ff,
  input wire logic spdif_out_source_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Tick through undivided first stage, then undivided converter stage
  sequence div_hop;
    clk_one_div_tick ##1 converter_clock_tick;
  endsequence
  AST_OPEN_DRAIN: assert property (sda_out_ff == 1'b0)
    else $error("data pin driven high");
  AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n |=> sda_oe_n_ff)
    else $error("data pin held in reset");
  // The synchroniser delay must still land inside the low phase
  AST_EDGE_SCL_LOW: assert property ($changed(sda_oe_n_ff) |-> !scl_in)
    else $error("data pin moved while clock high");
  AST_WRITE_ACKED: assert property ($past(rst_n) && ($changed(clock_ctrl_ff) || $changed(spdif_out_source_ff))
    |-> ##[0:1] !sda_oe_n_ff)
    else $error("register changed without ack");
  AST_LOOPBACK: assert property ($past(rst_n) && $stable(spdif_out_source_ff) |-> spdif_output_pin ==
    ($past(spdif_out_source_ff) ? $past(spdif_input_pin) : $past(transmitter_out)))
    else $error("output source wrong");
  AST_SRC_ONE: assert property (clock_ctrl_ff == 8'h00 && internal_clock_one |=> div_hop)
    else $error("first clock path lost a tick");
  AST_SRC_PLL: assert property ((clock_ctrl_ff == 8'h02 && pll_512fs_tick) ||
    (clock_ctrl_ff == 8'h03 && pll_256fs_tick) |=> converter_clock_tick)
    else $error("recovered clock not selected");
  AST_DIV3_GAP: assert property ($stable(clock_ctrl_ff) && clock_ctrl_ff[5:4] == 2'h3 && clk_two_div_tick
    |=> !clk_two_div_tick [*2])
    else $error("divide by three too fast");
  AST_STOP_IDLE: assert property (scl_in && $rose(sda_in) |-> ##[1:4] sda_oe_n_ff)
    else $error("data pin held after stop");
endmodule // ctrl_port_chk

bind codec_i2c_control_port ctrl_port_chk ctrl_port_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out_ff(sda_out_ff), .sda_oe_n_ff(sda_oe_n_ff),
  .internal_clock_one(internal_clock_one), .pll_512fs_tick(pll_512fs_tick), .pll_256fs_tick(pll_256fs_tick),
  .transmitter_out(transmitter_out), .spdif_input_pin(spdif_input_pin), .spdif_output_pin(spdif_output_pin),
  .clk_two_div_tick(clk_two_div_tick), .clk_one_div_tick(clk_one_div_tick),
  .converter_clock_tick(converter_clock_tick), .clock_ctrl_ff(clock_ctrl_ff),
  .spdif_out_source_ff(spdif_out_source_ff));
`default_nettype wire

// >>> tb/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus master model
// ****************
module i2c_host_model (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Five clocks per phase keeps the target's four-clock minimum
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Start and repeated start share one shape
  task automatic start();
    gap(1);
    sda_drv = 1'b1;
    gap(5);
    scl = 1'b1;
    gap(5);
    sda_drv = 1'b0;
    gap(5);
    scl = 1'b0;
  endtask
  task automatic stop();
    gap(1);
    sda_drv = 1'b0;
    gap(5);
    scl = 1'b1;
    gap(5);
    sda_drv = 1'b1;
    gap(5);
  endtask
  // Data moves only in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    gap(1);
    sda_drv = b;
    gap(5);
    scl = 1'b1;
    gap(4);
    r = sda_line;
    gap(1);
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  // Last byte of a read is refused to end the transfer
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // i2c_host_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clk_sys, rst_n, sel_hi, sel_lo, tx_bit, rx_bit, a;
  logic [3:0] tick_in; // One, two, pll512, pll256
  wire scl, sda_drv, sda_line, sda_out_ff, sda_oe_n_ff, out_pin, src_ff;
  wire [2:0] tick_out;
  wire [7:0] clock_ctrl_ff;
  int fail_count, tests_run, seed, cnt, osel;
  logic [7:0] mem [128]; // Register model
  logic [7:0] bufm [3][32]; // Buffer model
  logic [7:0] q [$];
  logic [6:0] cur;
  logic [4:0] bptr;
  // Pull-up wins unless someone pulls low
  assign sda_line = sda_drv & (sda_oe_n_ff | sda_out_ff);
  codec_i2c_control_port codec_i2c_control_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out_ff(sda_out_ff), .sda_oe_n_ff(sda_oe_n_ff), .bus_address_select_hi(sel_hi),
    .bus_address_select_lo(sel_lo), .internal_clock_one(tick_in[0]), .internal_clock_two(tick_in[1]),
    .pll_512fs_tick(tick_in[2]), .pll_256fs_tick(tick_in[3]), .transmitter_out(tx_bit),
    .spdif_input_pin(rx_bit), .spdif_output_pin(out_pin), .clk_one_div_tick(tick_out[0]),
    .clk_two_div_tick(tick_out[1]), .converter_clock_tick(tick_out[2]), .clock_ctrl_ff(clock_ctrl_ff),
    .spdif_out_source_ff(src_ff));
  i2c_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Random stream levels for both output sources
  always @(negedge clk_sys) {tx_bit, rx_bit} <= 2'($random(seed));
  always @(posedge clk_sys) cnt <= cnt + int'(tick_out[osel]);
  // ****************
  // Model and bus tasks
  // ****************
  task automatic step(input logic w, inout logic [7:0] d);
    if (cur >= 7'h7C && cur <= 7'h7E) begin
      if (w) bufm[cur - 7'h7C][bptr] = d;
      else d = bufm[cur - 7'h7C][bptr];
      bptr++;
    end else begin
      if (w) mem[cur] = (cur == 7'h03) ? (d & 8'h01) : d;
      else d = mem[cur];
      cur++;
    end
  endtask
  task automatic index(input logic [6:0] idx);
    host.start();
    host.wr_byte({5'h04, sel_hi, sel_lo, 1'b0}, a);
    `CHK("addr ack", 1'b0, a)
    host.wr_byte({idx, 1'b0}, a);
    `CHK("index ack", 1'b0, a)
    cur = idx;
    bptr = 5'h00;
  endtask
  task automatic wr(input logic [6:0] idx);
    index(idx);
    foreach (q[i]) begin
      host.wr_byte(q[i], a);
      `CHK("data ack", 1'b0, a)
      step(1'b1, q[i]);
    end
    host.stop();
    q = {};
    `CHK("clock reg", mem[0], clock_ctrl_ff)
    `CHK("source bit", mem[3][0], src_ff)
  endtask
  task automatic rd(input logic set, input logic [6:0] idx, input int n);
    logic [7:0] d, e;
    if (set) index(idx);
    host.start();
    host.wr_byte({5'h04, sel_hi, sel_lo, 1'b1}, a);
    `CHK("read ack", 1'b0, a)
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i == n - 1, d);
      step(1'b0, e);
      `CHK("read data", e, d)
    end
    host.stop();
  endtask
  // Warm up twelve ticks, then count twelve more
  task automatic ticks(input int s, input int o, input int e);
    int base;
    osel = o;
    base = 0;
    for (int i = 0; i < 24; i++) begin
      if (i == 12) begin
        repeat (4) @(negedge clk_sys);
        base = cnt;
      end
      @(negedge clk_sys);
      tick_in[s] = 1'b1;
      @(negedge clk_sys);
      tick_in[s] = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    `CHK("tick count", e, cnt - base)
  endtask
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    seed = 32'h645FB9A7;
    rst_n = 1'b0;
    tick_in = 4'h0;
    {sel_hi, sel_lo} = 2'h0;
    mem[0] = 8'h00;
    mem[3] = 8'h00;
    osel = 0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int k = 0; k < 4; k++) begin
      {sel_hi, sel_lo} = 2'(k);
      host.start();
      host.wr_byte({5'h04, ~sel_hi, sel_lo, 1'b0}, a);
      `CHK("foreign ack", 1'b1, a)
      host.stop();
      q = {8'($random(seed)), 8'($random(seed)), 8'(k) & 8'h01};
      wr(7'h01);
      rd(1'b1, 7'h01, 3);
    end
    q = {8'($random(seed))};
    wr(7'h00);
    rd(1'b1, 7'h00, 1);
    // Pointer-only write, then read from the kept index
    wr(7'h02);
    rd(1'b0, 7'h02, 2);
    for (int b = 0; b < 3; b++) begin
      q = {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
      wr(7'(7'h7C + b));
      rd(1'b1, 7'(7'h7C + b), 3);
    end
    // Each divider field, codes 00 to 11 give 12, 8, 6, 4 of 12
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < 4; c++) begin
        q = {8'(c << (2 + 2 * f))};
        wr(7'h00);
        ticks((f == 1) ? 1 : 0, f, (c == 0) ? 12 : (c == 1) ? 8 : (c == 2) ? 6 : 4);
      end
    end
    for (int s = 1; s < 4; s++) begin
      q = {8'(s)};
      wr(7'h00);
      ticks(s, 2, 12);
    end
    q = {8'h00};
    wr(7'h03);
    close_out();
  end
  initial begin
    #(100 * 60000);
    fail_count++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
